// *** afc_consts.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH

`define AFC_ADDR_W              13
`define AFC_OFS_FEATURES        13'h002a
`define AFC_OFS_OUT_ASSIGN      13'h002e
`define AFC_OFS_SYNC_CTRL       13'h0100
`define AFC_OFS_USER_CFG2       13'h0101

`define AFC_RST_FEATURES        8'h01
`define AFC_RST_ASSIGN_A        8'h00
`define AFC_RST_ASSIGN_B        8'h01
`define AFC_RST_SYNC_CTRL       8'h01
`define AFC_RST_USER_CFG2       8'h88

`define AFC_SYNC_MASTER_BIT     0
`define AFC_SYNC_DIV_EN_BIT     1
`define AFC_SYNC_NEXT_ONLY_BIT  2
`define AFC_SYNC_USED_MASK      8'h07
`define AFC_CFG2_OE_PIN_BIT     7
`define AFC_CFG2_DETECT_BIT     3
`define AFC_CFG2_RUN_OSC_BIT    2
`define AFC_CFG2_PD_DIS_BIT     0
`define AFC_CFG2_USED_MASK      8'h8d
`define AFC_CH_USED_MASK        8'h01

// Low-rate detector: encode period longer than 1/5 MSPS = 200 ns
`define AFC_CLK_HZ              20000000
`define AFC_LOW_RATE_HZ         5000000
`define AFC_LOW_RATE_CYC        (`AFC_CLK_HZ / `AFC_LOW_RATE_HZ)

`endif

// *** afc_pkg.sv ***
// Types shared by the feature-control block
package afc_pkg;
  typedef logic [7:0]  afc_byte_t;
  typedef logic [12:0] afc_addr_t;
  typedef enum logic [1:0] {
    AFC_SY_IDLE  = 2'b00,
    AFC_SY_ARMED = 2'b01,
    AFC_SY_DONE  = 2'b10
  } afc_sync_state_t;
endpackage : afc_pkg

// *** afc_chan_regs.sv ***
// Per-channel feature and output-assign registers
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.svh"
module afc_chan_regs
  import afc_pkg::*;
#(
  parameter int NCH = 2
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // Write port
  input  wire logic                 wr_feat,
  input  wire logic                 wr_assign,
  input  wire logic [NCH-1:0]       ch_sel,
  input  wire afc_pkg::afc_byte_t   wdata,
  // Per-channel state
  output logic      [NCH-1:0]       or_en_ff,
  output logic      [NCH-1:0]       assign_b_ff
);
  import afc_pkg::*;

  logic [NCH-1:0] nxt_or_en;
  logic [NCH-1:0] nxt_assign_b;

  always_comb begin
    nxt_or_en    = or_en_ff;
    nxt_assign_b = assign_b_ff;
    for (int i = 0; i < NCH; i++) begin
      if (wr_feat && ch_sel[i]) begin
        nxt_or_en[i] = wdata[0];
      end
      if (wr_assign && ch_sel[i]) begin
        nxt_assign_b[i] = wdata[0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      or_en_ff    <= '1;
      assign_b_ff <= NCH'(2);
    end else begin
      or_en_ff    <= nxt_or_en;
      assign_b_ff <= nxt_assign_b;
    end
  end
endmodule : afc_chan_regs
`default_nettype wire

// *** afc_feature_ctrl.sv ***
// Digital feature-control registers of a dual-channel converter
// Behaviour
// - No sync action at all unless master sync enable is high.
// - Sync pulse reaches divider only when divider enable and master enable high.
// - Next-only low: the first sync pulse resynchronizes the divider, then divider enable clears.
// - Next-only high: align on first pulse, ignore later ones.
// - Divider sync enable clears itself after a completed sync.
// - Output-enable pin controls outputs only when its enable bit is high.
// - Detect enable high: low encode rate below about 5 MSPS starts oscillator.
// - Detect enable low: detector cannot start the oscillator.
// - Run-oscillator bit forces the oscillator on regardless of detector.
// - Pull-down disable bit high disconnects the serial data pin pull-down.
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.svh"
module afc_feature_ctrl
  import afc_pkg::*;
#(
  parameter int NCH = 2
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // Register access from the serial port decoder
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire afc_pkg::afc_addr_t   reg_addr,
  input  wire afc_pkg::afc_byte_t   reg_wdata,
  input  wire logic [NCH-1:0]       ch_index,
  output afc_pkg::afc_byte_t        reg_rdata_ff,
  // Pins and clocks from outside
  input  wire logic                 sync_pin,
  input  wire logic                 output_enable_bar_pin,
  input  wire logic                 encode_clk_pin,
  // Controls to the converter
  output logic                      div_sync_ff,
  output logic                      low_rate_internal_oscillator_ff,
  output logic                      outputs_enabled_ff,
  output logic                      sdio_pulldown_on_ff,
  output logic [NCH-1:0]            or_out_en_ff,
  output logic [NCH-1:0]            chan_src_b_ff
);
  import afc_pkg::*;

  localparam int DW = $clog2(`AFC_LOW_RATE_CYC + 2);

  afc_byte_t       sync_ctrl_ff, nxt_sync_ctrl;
  afc_byte_t       cfg2_ff, nxt_cfg2;
  afc_sync_state_t sy_state_ff, nxt_sy_state;
  logic [2:0]      sync_s_ff, nxt_sync_s;
  logic [2:0]      enc_s_ff, nxt_enc_s;
  logic [1:0]      oe_s_ff, nxt_oe_s;
  logic [DW-1:0]   gap_ff, nxt_gap;
  logic            low_rate_ff, nxt_low_rate;
  afc_byte_t       nxt_rdata;
  logic            nxt_div_sync;
  logic            sync_edge;
  logic [NCH-1:0]  or_en, assign_b;

  function automatic logic hit(input afc_addr_t a, input afc_addr_t ofs);
    return reg_wr && (a == ofs);
  endfunction : hit

  afc_chan_regs #(.NCH(NCH)) u_chan (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .wr_feat     (hit(reg_addr, `AFC_OFS_FEATURES)),
    .wr_assign   (hit(reg_addr, `AFC_OFS_OUT_ASSIGN)),
    .ch_sel      (ch_index),
    .wdata       (reg_wdata),
    .or_en_ff    (or_en),
    .assign_b_ff (assign_b)
  );

  // Synchronisers: stage 0 only feeds stage 1
  always_comb begin
    nxt_sync_s = {sync_s_ff[1:0], sync_pin};
    nxt_enc_s  = {enc_s_ff[1:0], encode_clk_pin};
    nxt_oe_s   = {oe_s_ff[0], output_enable_bar_pin};
  end
  assign sync_edge = sync_s_ff[1] & ~sync_s_ff[2];

  // Sync gating and self-clearing divider enable
  always_comb begin
    nxt_sync_ctrl = sync_ctrl_ff;
    nxt_sy_state  = sy_state_ff;
    nxt_div_sync  = 1'b0;
    if (hit(reg_addr, `AFC_OFS_SYNC_CTRL)) begin
      nxt_sync_ctrl = reg_wdata & `AFC_SYNC_USED_MASK;
      nxt_sy_state  = AFC_SY_IDLE;
    end
    if (sync_ctrl_ff[`AFC_SYNC_MASTER_BIT] && sync_ctrl_ff[`AFC_SYNC_DIV_EN_BIT]) begin
      case (sy_state_ff)
        AFC_SY_IDLE: begin
          if (sync_edge) begin
            nxt_div_sync = 1'b1;
            if (sync_ctrl_ff[`AFC_SYNC_NEXT_ONLY_BIT]) begin
              nxt_sy_state = AFC_SY_DONE;
            end
            // Hardware clear wins over a same-cycle write
            nxt_sync_ctrl[`AFC_SYNC_DIV_EN_BIT] = 1'b0;
          end
        end
        AFC_SY_DONE: nxt_div_sync = 1'b0;
        default:     nxt_sy_state = AFC_SY_IDLE;
      endcase
    end
    // Continuous mode: state stays idle; only one pulse resyncs until enable is rewritten
    if (!sync_ctrl_ff[`AFC_SYNC_NEXT_ONLY_BIT] && sy_state_ff == AFC_SY_IDLE) begin
      nxt_sy_state = AFC_SY_IDLE;
    end
  end

  // User config two and low encode rate detector
  always_comb begin
    nxt_cfg2 = cfg2_ff;
    if (hit(reg_addr, `AFC_OFS_USER_CFG2)) begin
      nxt_cfg2 = reg_wdata & `AFC_CFG2_USED_MASK;
    end
    nxt_low_rate = low_rate_ff;
    nxt_gap      = gap_ff;
    if (enc_s_ff[1] != enc_s_ff[2]) begin
      nxt_gap = '0;
      if (enc_s_ff[1]) begin
        nxt_low_rate = 1'b0;
      end
    end else if (gap_ff <= DW'(`AFC_LOW_RATE_CYC)) begin
      nxt_gap = gap_ff + DW'(1);
    end else begin
      nxt_low_rate = 1'b1;
    end
    if (!cfg2_ff[`AFC_CFG2_DETECT_BIT]) begin
      nxt_low_rate = 1'b0;
      nxt_gap      = '0;
    end
  end

  // Read mux; unused bits already masked to zero
  always_comb begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        `AFC_OFS_FEATURES:   nxt_rdata = {7'h00, |(or_en & ch_index)};
        `AFC_OFS_OUT_ASSIGN: nxt_rdata = {7'h00, |(assign_b & ch_index)};
        `AFC_OFS_SYNC_CTRL:  nxt_rdata = sync_ctrl_ff;
        `AFC_OFS_USER_CFG2:  nxt_rdata = cfg2_ff;
        default:             nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_ctrl_ff                    <= `AFC_RST_SYNC_CTRL;
      cfg2_ff                         <= `AFC_RST_USER_CFG2;
      sy_state_ff                     <= AFC_SY_IDLE;
      sync_s_ff                       <= 3'h0;
      enc_s_ff                        <= 3'h0;
      oe_s_ff                         <= 2'h0;
      gap_ff                          <= '0;
      low_rate_ff                     <= 1'b0;
      reg_rdata_ff                    <= 8'h00;
      div_sync_ff                     <= 1'b0;
      low_rate_internal_oscillator_ff <= 1'b0;
      outputs_enabled_ff              <= 1'b1;
      sdio_pulldown_on_ff             <= 1'b1;
      or_out_en_ff                    <= '0;
      chan_src_b_ff                   <= '0;
    end else begin
      sync_ctrl_ff                    <= nxt_sync_ctrl;
      cfg2_ff                         <= nxt_cfg2;
      sy_state_ff                     <= nxt_sy_state;
      sync_s_ff                       <= nxt_sync_s;
      enc_s_ff                        <= nxt_enc_s;
      oe_s_ff                         <= nxt_oe_s;
      gap_ff                          <= nxt_gap;
      low_rate_ff                     <= nxt_low_rate;
      reg_rdata_ff                    <= nxt_rdata;
      div_sync_ff                     <= nxt_div_sync;
      low_rate_internal_oscillator_ff <= low_rate_ff | cfg2_ff[`AFC_CFG2_RUN_OSC_BIT];
      // Pin ignored while its enable is low
      outputs_enabled_ff              <= ~(cfg2_ff[`AFC_CFG2_OE_PIN_BIT] & oe_s_ff[1]);
      sdio_pulldown_on_ff             <= ~cfg2_ff[`AFC_CFG2_PD_DIS_BIT];
      or_out_en_ff                    <= or_en;
      chan_src_b_ff                   <= assign_b;
    end
  end
endmodule : afc_feature_ctrl
`default_nettype wire

// *** afc_host_model.sv ***
// Host model driving the feature block register port
`timescale 1ns/1ns
`default_nettype none
module afc_host_model
  import afc_pkg::*;
(
  // Clock
  input  wire logic               ref_clk,
  // Register port
  output logic                    reg_wr,
  output logic                    reg_rd,
  output afc_pkg::afc_addr_t      reg_addr,
  output afc_pkg::afc_byte_t      reg_wdata,
  output logic [1:0]              ch_index,
  input  wire afc_pkg::afc_byte_t reg_rdata_ff
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 13'h0000;
    reg_wdata = 8'h00;
    ch_index = 2'b01;
  end
  // One strobe cycle, then idle with scrambled address and data
  task automatic xfer(input logic w, input afc_addr_t a, input afc_byte_t d, input logic [1:0] c,
                      output afc_byte_t q);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    ch_index <= c;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(negedge ref_clk);
    @(negedge ref_clk);
    q = reg_rdata_ff;
  endtask : xfer
endmodule : afc_host_model
`default_nettype wire

// *** afc_feature_ctrl_chk.sv ***
// Port assertions for the feature block
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.svh"
module afc_feature_ctrl_chk
  import afc_pkg::*;
(
  // Clock, reset and writes
  input wire logic               ref_clk,
  input wire logic               rst_b,
  input wire logic               reg_wr,
  input wire afc_pkg::afc_addr_t reg_addr,
  input wire afc_pkg::afc_byte_t reg_wdata,
  // Pins and controls
  input wire logic               sync_pin,
  input wire logic               output_enable_bar_pin,
  input wire logic               encode_clk_pin,
  input wire logic               div_sync_ff,
  input wire logic               low_rate_internal_oscillator_ff,
  input wire logic               outputs_enabled_ff,
  input wire logic               sdio_pulldown_on_ff
);
  logic      mst_ff;
  logic      en_ff;
  afc_byte_t cfg_ff;
  wire wr_sy = reg_wr && reg_addr == `AFC_OFS_SYNC_CTRL;
  wire det = cfg_ff[`AFC_CFG2_DETECT_BIT];
  wire run = cfg_ff[`AFC_CFG2_RUN_OSC_BIT];
  wire osc = low_rate_internal_oscillator_ff;
  // Shadow of host writes; divider enable drops on each sync
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mst_ff <= 1'b1;
      en_ff <= 1'b0;
      cfg_ff <= `AFC_RST_USER_CFG2;
    end else begin
      if (wr_sy) mst_ff <= reg_wdata[0];
      if (div_sync_ff) en_ff <= 1'b0;
      else if (wr_sy) en_ff <= reg_wdata[1];
      if (reg_wr && reg_addr == `AFC_OFS_USER_CFG2) cfg_ff <= reg_wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_armed; mst_ff && en_ff && $rose(sync_pin); endsequence
  sequence s_quiet; (det && $stable(encode_clk_pin)) [*8]; endsequence
  property p_gate; div_sync_ff |-> mst_ff && en_ff; endproperty
  property p_resync; s_armed |-> ##[2:6] div_sync_ff; endproperty
  property p_pulse; div_sync_ff |=> !div_sync_ff; endproperty
  property p_detect; s_quiet ##1 (det && $stable(encode_clk_pin)) [*3] |=> osc; endproperty
  property p_det_off; (!det && !run) [*4] |-> !osc; endproperty
  property p_run; run [*3] |-> osc; endproperty
  property p_oe; ($stable(cfg_ff[7]) && $stable(output_enable_bar_pin)) [*4] |->
    outputs_enabled_ff == !(cfg_ff[7] && output_enable_bar_pin); endproperty
  property p_pd; $stable(cfg_ff[0]) [*3] |-> sdio_pulldown_on_ff == !cfg_ff[0]; endproperty
  a_gate: assert property (p_gate) else $error("sync while gated");
  a_resync: assert property (p_resync) else $error("no sync");
  a_pulse: assert property (p_pulse) else $error("long sync");
  a_detect: assert property (p_detect) else $error("no osc");
  a_det_off: assert property (p_det_off) else $error("osc on");
  a_run: assert property (p_run) else $error("osc off");
  a_oe: assert property (p_oe) else $error("out enable");
  a_pd: assert property (p_pd) else $error("pulldown");
endmodule : afc_feature_ctrl_chk
bind afc_feature_ctrl afc_feature_ctrl_chk u_chk (.ref_clk, .rst_b, .reg_wr, .reg_addr, .reg_wdata,
  .sync_pin, .output_enable_bar_pin, .encode_clk_pin, .div_sync_ff,
  .low_rate_internal_oscillator_ff, .outputs_enabled_ff, .sdio_pulldown_on_ff);
`default_nettype wire

// *** afc_feature_ctrl_tb.sv ***
// Self-checking bench for the feature block
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.svh"
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, ex, ac); end end
module afc_feature_ctrl_tb;
  import afc_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       sync_pin = 1'b0;
  logic       output_enable_bar_pin = 1'b0;
  logic       encode_clk_pin = 1'b0;
  logic       enc_run = 1'b1;
  logic       reg_wr, reg_rd, div_sync_ff, osc, outputs_enabled_ff, sdio_pulldown_on_ff;
  logic [1:0] ch_index, or_out_en_ff, chan_src_b_ff;
  afc_addr_t  reg_addr;
  afc_byte_t  reg_wdata, reg_rdata_ff, q;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         syncs = 0;
  afc_host_model host (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .ch_index, .reg_rdata_ff);
  afc_feature_ctrl #(.NCH(2)) dut (.ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .ch_index, .reg_rdata_ff, .sync_pin, .output_enable_bar_pin, .encode_clk_pin, .div_sync_ff,
    .low_rate_internal_oscillator_ff(osc), .outputs_enabled_ff, .sdio_pulldown_on_ff,
    .or_out_en_ff, .chan_src_b_ff);
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (enc_run) encode_clk_pin <= ~encode_clk_pin;
  always @(negedge ref_clk) if (div_sync_ff === 1'b1) syncs++;
  task automatic w(input afc_addr_t a, input afc_byte_t d, input logic [1:0] c = 2'b01);
    host.xfer(1'b1, a, d, c, q);
  endtask : w
  task automatic rc(input afc_addr_t a, input afc_byte_t e, input logic [1:0] c = 2'b01);
    host.xfer(1'b0, a, 8'h00, c, q);
    `CHK("rdata", e, q)
  endtask : rc
  task automatic hold(input int n = 14);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : hold
  // Sync pin pulse, then count divider syncs
  task automatic pulse(input int n);
    syncs = 0;
    @(posedge ref_clk);
    sync_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sync_pin <= 1'b0;
    hold(8);
    `CHK("syncs", n, syncs)
  endtask : pulse
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    w(13'h0055, 8'hff);
    rc(13'h0055, 8'h00);
    rc(`AFC_OFS_FEATURES, `AFC_RST_FEATURES);
    rc(`AFC_OFS_OUT_ASSIGN, `AFC_RST_ASSIGN_A);
    rc(`AFC_OFS_OUT_ASSIGN, `AFC_RST_ASSIGN_B, 2'b10);
    rc(`AFC_OFS_SYNC_CTRL, `AFC_RST_SYNC_CTRL);
    rc(`AFC_OFS_USER_CFG2, `AFC_RST_USER_CFG2);
    `CHK("pulldown", 1'b1, sdio_pulldown_on_ff)
    $display("test reset done");
    w(`AFC_OFS_FEATURES, 8'h00);
    w(`AFC_OFS_OUT_ASSIGN, 8'h00, 2'b10);
    hold();
    `CHK("range_oe", 2'b10, or_out_en_ff)
    `CHK("src_b", 2'b00, chan_src_b_ff)
    w(`AFC_OFS_FEATURES, 8'hff, 2'b11);
    rc(`AFC_OFS_FEATURES, 8'h01, 2'b10);
    $display("test channels done");
    w(`AFC_OFS_SYNC_CTRL, 8'h02);
    pulse(0);
    w(`AFC_OFS_SYNC_CTRL, 8'h01);
    pulse(0);
    w(`AFC_OFS_SYNC_CTRL, 8'h03);
    pulse(1);
    rc(`AFC_OFS_SYNC_CTRL, 8'h01);
    w(`AFC_OFS_SYNC_CTRL, 8'h07);
    pulse(1);
    pulse(0);
    rc(`AFC_OFS_SYNC_CTRL, 8'h05);
    w(`AFC_OFS_SYNC_CTRL, 8'hf8);
    rc(`AFC_OFS_SYNC_CTRL, 8'h00);
    $display("test sync done");
    @(posedge ref_clk);
    output_enable_bar_pin <= 1'b1;
    hold();
    `CHK("out_en", 1'b0, outputs_enabled_ff)
    w(`AFC_OFS_USER_CFG2, 8'h08);
    hold();
    `CHK("out_en", 1'b1, outputs_enabled_ff)
    @(posedge ref_clk);
    enc_run <= 1'b0;
    hold();
    `CHK("osc", 1'b1, osc)
    @(posedge ref_clk);
    enc_run <= 1'b1;
    hold();
    `CHK("osc", 1'b0, osc)
    w(`AFC_OFS_USER_CFG2, 8'h01);
    @(posedge ref_clk);
    enc_run <= 1'b0;
    hold();
    `CHK("osc", 1'b0, osc)
    `CHK("pulldown", 1'b0, sdio_pulldown_on_ff)
    w(`AFC_OFS_USER_CFG2, 8'hff);
    hold();
    `CHK("osc", 1'b1, osc)
    rc(`AFC_OFS_USER_CFG2, 8'h8d);
    $display("test config done");
    // Mid-run reset restores registers, channel controls and pull-down; out enable follows the high pin
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    hold();
    `CHK("range_oe", 2'b11, or_out_en_ff)
    `CHK("src_b", 2'b10, chan_src_b_ff)
    `CHK("pulldown", 1'b1, sdio_pulldown_on_ff)
    `CHK("out_en", 1'b0, outputs_enabled_ff)
    rc(`AFC_OFS_SYNC_CTRL, `AFC_RST_SYNC_CTRL);
    rc(`AFC_OFS_USER_CFG2, `AFC_RST_USER_CFG2);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : afc_feature_ctrl_tb
`default_nettype wire
